// [logic/fsr_map.vh]
// How it works
// - ID read after three writes returns identifier when A6,A1,A0=0,0,1, main select.
// - Same mode with A6,A1,A0=0,1,0 returns 01h protected, 00h unprotected.
// - Busy reads give status: bit7 poll, bit6 toggle, bit5 error, bit3 window.
// - Program shows inverted data bit 7 on poll bit, true data after.
// - Poll bit valid after fourth program write or sixth erase write.
// - Poll bit reads zero during erase; erased bytes read one afterwards.
// - Program into a protected sector is silently dropped.
// - All-protected erase holds poll and toggle at zero ~100 us, erases nothing.
// - Toggle bit flips on every selected read while an operation runs, except during an all-protected erase.
// - Toggling stops at completion; reads return array bytes again.
// - Toggle bit meaningful after fourth program or sixth erase write.
// - Error bit zero on good operations, one on program or erase failure.
// - Error on program turning a zero into one, or program timeout.
// - Error bit cleared only by the reset command.
// - Window bit zero 120 us after sector erase, one on expiry or next one.
// - Erase fills sectors with FF; program only clears bits, byte-wise.
// - Erase status readable at any address in the erased array.
// - F0 returns to array read after ID, protection read or error.
`ifndef FSR_MAP_VH
`define FSR_MAP_VH

// Command cycle addresses and data
`define FSR_ADDR1 12'h555
`define FSR_ADDR2 12'haaa
`define FSR_UNLOCK1 8'haa
`define FSR_UNLOCK2 8'h55
`define FSR_CMD_ID 8'h90
`define FSR_CMD_PGM 8'ha0
`define FSR_CMD_ERASE 8'h80
`define FSR_CMD_SECT 8'h30
`define FSR_CMD_BULK 8'h10
`define FSR_CMD_RESET 8'hf0

// Identifier read address patterns on A6,A1,A0
`define FSR_PAT_ID 3'h1
`define FSR_PAT_PROT 3'h2

// Status byte bit positions
`define FSR_BIT_POLL 7
`define FSR_BIT_TOGGLE 6
`define FSR_BIT_ERR 5
`define FSR_BIT_EWIN 3

// Timing
`define FSR_CLK_MHZ 20
`define FSR_EWIN_US 120
`define FSR_PROT_US 100

// Bulk erase sector masks
`define FSR_MASK_MAIN 12'h0ff
`define FSR_MASK_BOOT 12'hf00

// AXI register offsets
`define FSR_REG_CTRL 8'h00
`define FSR_REG_PROT 8'h04
`define FSR_REG_STAT 8'h08
`define FSR_REG_ID 8'h0c

// AXI reset values and responses
`define FSR_CTRL_RST 1'b0
`define FSR_PROT_RST 12'h000
`define FSR_RESP_OK 2'b00
`define FSR_RESP_ERR 2'b10

`endif

// [logic/fsr_core.v]
// Chosen here: the register addresses and the AXI4-Lite slave port.
`include "fsr_map.vh"

module fsr_core #(
   parameter SECT_AW = 4,
   parameter PROG_CYC = 16,
   parameter ERASE_CYC = 256,
   parameter [7:0] MAIN_ID = 8'h5a // Arbitrary identifier value
) (
   // Clock and reset
   input wire mclk,
   input wire srst,
   // Microcontroller flash bus
   input wire [15:0] mcu_addr,
   input wire [7:0] mcu_wdata,
   input wire mcu_wr,
   input wire mcu_rd,
   input wire [7:0] main_array_sector_select,
   input wire [3:0] secondary_array_sector_select,
   output reg [7:0] mcu_rdata,
   output reg mcu_rvalid,
   // AXI4-Lite write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   localparam AW = SECT_AW + 4;
   localparam DEPTH = 1 << AW;
   localparam [15:0] EWIN_CYC = `FSR_EWIN_US * `FSR_CLK_MHZ;
   localparam [15:0] PROT_CYC = `FSR_PROT_US * `FSR_CLK_MHZ;
   localparam [15:0] PROG_END = PROG_CYC - 1;
   localparam [15:0] ERASE_END = ERASE_CYC - 1;

   // Command states
   localparam [3:0] S_READ = 4'h0;
   localparam [3:0] S_C1 = 4'h1;
   localparam [3:0] S_C2 = 4'h2;
   localparam [3:0] S_ID = 4'h3;
   localparam [3:0] S_PGM = 4'h4;
   localparam [3:0] S_E3 = 4'h5;
   localparam [3:0] S_E4 = 4'h6;
   localparam [3:0] S_E5 = 4'h7;
   localparam [3:0] S_EWIN = 4'h8;
   localparam [3:0] S_BUSY_P = 4'h9;
   localparam [3:0] S_BUSY_E = 4'ha;
   localparam [3:0] S_PROT_E = 4'hb;
   localparam [3:0] S_ERR = 4'hc;

   reg [7:0] mem [0:DEPTH-1];
   reg [3:0] state_reg;
   reg [15:0] cnt_reg;
   reg [AW-1:0] pa_reg;
   reg [7:0] pd_reg;
   reg [11:0] emask_reg;
   reg op_boot_reg;
   reg op_pgm_reg;
   reg err_reg;
   reg tog_reg;
   reg ewin_reg;
   reg ctrl_fail_reg;
   reg [11:0] prot_reg;
   reg aw_full_reg;
   reg w_full_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg [3:0] sect_idx;
   reg [7:0] status_byte;
   reg mem_we;
   reg [AW-1:0] mem_wa;
   reg [7:0] mem_wd;
   reg [31:0] axi_rd_val;
   reg axi_rd_ok;
   integer i;

   wire main_sel = |main_array_sector_select;
   wire boot_sel = |secondary_array_sector_select;
   wire wr = mcu_wr & (main_sel | boot_sel);
   wire rd = mcu_rd & (main_sel | boot_sel);
   wire [11:0] a12 = mcu_addr[11:0];
   wire [2:0] pat = {mcu_addr[6], mcu_addr[1], mcu_addr[0]};
   wire [AW-1:0] acc_addr = {sect_idx, mcu_addr[SECT_AW-1:0]};
   wire sect_prot = prot_reg[sect_idx];
   wire [7:0] mem_q = mem[acc_addr];
   wire [7:0] pq = mem[pa_reg];
   wire [11:0] bulk_mask = boot_sel ? `FSR_MASK_BOOT : `FSR_MASK_MAIN;
   wire bulk_all_prot = ~|(bulk_mask & ~prot_reg);
   wire ewin_all_prot = ~|(emask_reg & ~prot_reg);
   wire [3:0] walk_sect = cnt_reg[AW-1:SECT_AW];
   wire busy = (state_reg == S_BUSY_P) | (state_reg == S_BUSY_E) |
      (state_reg == S_PROT_E) | (state_reg == S_EWIN) |
      (state_reg == S_ERR);
   wire in_op_array = (boot_sel == op_boot_reg);
   wire is_reset = wr & (mcu_wdata == `FSR_CMD_RESET);
   wire c1_ok = wr & (a12 == `FSR_ADDR1) & (mcu_wdata == `FSR_UNLOCK1);
   wire c2_ok = wr & (a12 == `FSR_ADDR2) & (mcu_wdata == `FSR_UNLOCK2);
   wire at1 = a12 == `FSR_ADDR1;

   // Sector index: main selects first, then secondary
   always @* begin
      sect_idx = 4'h0;
      for (i = 3; i >= 0; i = i - 1) begin
         if (secondary_array_sector_select[i]) begin
            sect_idx = 4'h8 + i[3:0];
         end
      end
      for (i = 7; i >= 0; i = i - 1) begin
         if (main_array_sector_select[i]) begin
            sect_idx = i[3:0];
         end
      end
   end

   // Status byte seen while busy
   always @* begin
      status_byte = 8'h00;
      if (op_pgm_reg) begin
         status_byte[`FSR_BIT_POLL] = ~pd_reg[7];
      end
      if (state_reg != S_PROT_E) begin
         status_byte[`FSR_BIT_TOGGLE] = tog_reg;
      end
      status_byte[`FSR_BIT_ERR] = err_reg;
      status_byte[`FSR_BIT_EWIN] = ~op_pgm_reg &
         ((state_reg != S_EWIN) | ewin_reg);
   end

   // Array write port: program commit or erase walk
   always @* begin
      mem_we = 1'b0;
      mem_wa = pa_reg;
      mem_wd = pq & pd_reg;
      if (state_reg == S_BUSY_P && cnt_reg == PROG_END) begin
         mem_we = 1'b1;
      end
      if (state_reg == S_BUSY_E && cnt_reg < DEPTH && walk_sect < 4'hc &&
          emask_reg[walk_sect] && !prot_reg[walk_sect]) begin
         mem_we = 1'b1;
         mem_wa = cnt_reg[AW-1:0];
         mem_wd = 8'hff;
      end
   end

   // Array storage
   always @(posedge mclk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // Command sequencer
   always @(posedge mclk) begin
      if (srst) begin
         state_reg <= S_READ;
         cnt_reg <= 16'h0000;
         pa_reg <= {AW{1'b0}};
         pd_reg <= 8'h00;
         emask_reg <= 12'h000;
         op_boot_reg <= 1'b0;
         op_pgm_reg <= 1'b0;
         err_reg <= 1'b0;
         ewin_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         case (state_reg)
            S_READ: begin
               if (c1_ok) begin
                  state_reg <= S_C1;
               end
            end
            S_C1: begin
               if (wr) begin
                  state_reg <= c2_ok ? S_C2 : S_READ;
               end
            end
            S_C2: begin
               if (wr) begin
                  state_reg <= S_READ;
                  if (at1 && mcu_wdata == `FSR_CMD_ID) begin
                     state_reg <= S_ID;
                  end
                  if (at1 && mcu_wdata == `FSR_CMD_PGM) begin
                     state_reg <= S_PGM;
                  end
                  if (at1 && mcu_wdata == `FSR_CMD_ERASE) begin
                     state_reg <= S_E3;
                  end
               end
            end
            S_ID: begin
               if (is_reset) begin
                  state_reg <= S_READ;
               end
            end
            S_PGM: begin
               if (wr) begin
                  if (sect_prot) begin
                     state_reg <= S_READ;
                  end else begin
                     state_reg <= S_BUSY_P;
                     pa_reg <= acc_addr;
                     pd_reg <= mcu_wdata;
                     op_boot_reg <= boot_sel;
                     op_pgm_reg <= 1'b1;
                     cnt_reg <= 16'h0000;
                  end
               end
            end
            S_E3: begin
               if (wr) begin
                  state_reg <= c1_ok ? S_E4 : S_READ;
               end
            end
            S_E4: begin
               if (wr) begin
                  state_reg <= c2_ok ? S_E5 : S_READ;
               end
            end
            S_E5: begin
               if (wr) begin
                  state_reg <= S_READ;
                  op_boot_reg <= boot_sel;
                  op_pgm_reg <= 1'b0;
                  cnt_reg <= 16'h0000;
                  ewin_reg <= 1'b0;
                  if (mcu_wdata == `FSR_CMD_SECT) begin
                     state_reg <= S_EWIN;
                     emask_reg <= 12'h001 << sect_idx;
                  end
                  if (at1 && mcu_wdata == `FSR_CMD_BULK) begin
                     emask_reg <= bulk_mask;
                     state_reg <= bulk_all_prot ? S_PROT_E : S_BUSY_E;
                  end
               end
            end
            S_EWIN: begin
               if (wr && mcu_wdata == `FSR_CMD_SECT) begin
                  emask_reg <= emask_reg | (12'h001 << sect_idx);
                  cnt_reg <= 16'h0000;
                  ewin_reg <= 1'b1;
               end else if (wr) begin
                  state_reg <= S_READ;
               end else if (cnt_reg == EWIN_CYC - 16'h0001) begin
                  cnt_reg <= 16'h0000;
                  state_reg <= ewin_all_prot ? S_PROT_E : S_BUSY_E;
               end
            end
            S_BUSY_P: begin
               if (cnt_reg == PROG_END) begin
                  state_reg <= S_READ;
                  if ((|(~pq & pd_reg)) || ctrl_fail_reg) begin
                     state_reg <= S_ERR;
                     err_reg <= 1'b1;
                  end
               end
            end
            S_BUSY_E: begin
               if (cnt_reg == ERASE_END) begin
                  state_reg <= S_READ;
                  if (ctrl_fail_reg) begin
                     state_reg <= S_ERR;
                     err_reg <= 1'b1;
                  end
               end
            end
            S_PROT_E: begin
               if (cnt_reg == PROT_CYC - 16'h0001) begin
                  state_reg <= S_READ;
               end
            end
            S_ERR: begin
               if (is_reset) begin
                  state_reg <= S_READ;
                  err_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= S_READ;
            end
         endcase
         if (is_reset && state_reg <= S_E5) begin
            state_reg <= S_READ;
         end
      end
   end

   // Read data path
   always @(posedge mclk) begin
      if (srst) begin
         mcu_rdata <= 8'h00;
         mcu_rvalid <= 1'b0;
         tog_reg <= 1'b0;
      end else begin
         mcu_rvalid <= rd;
         if (rd) begin
            mcu_rdata <= mem_q;
            if (busy && state_reg != S_PROT_E) begin
               tog_reg <= ~tog_reg;
            end
            if (busy && in_op_array) begin
               mcu_rdata <= status_byte;
            end else if (state_reg == S_ID) begin
               if (pat == `FSR_PAT_ID && main_sel) begin
                  mcu_rdata <= MAIN_ID;
               end
               if (pat == `FSR_PAT_PROT) begin
                  mcu_rdata <= {7'h00, sect_prot};
               end
            end
         end
      end
   end

   // AXI write: address and data in either order
   assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;

   always @(posedge mclk) begin
      if (srst) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FSR_RESP_OK;
         ctrl_fail_reg <= `FSR_CTRL_RST;
         prot_reg <= `FSR_PROT_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (aw_full_reg && w_full_reg) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `FSR_RESP_OK;
            case (aw_addr_reg)
               `FSR_REG_CTRL: begin
                  if (w_strb_reg[0]) begin
                     ctrl_fail_reg <= w_data_reg[0];
                  end
               end
               `FSR_REG_PROT: begin
                  if (w_strb_reg[0]) begin
                     prot_reg[7:0] <= w_data_reg[7:0];
                  end
                  if (w_strb_reg[1]) begin
                     prot_reg[11:8] <= w_data_reg[11:8];
                  end
               end
               `FSR_REG_STAT, `FSR_REG_ID: begin
                  s_axi_bresp <= `FSR_RESP_OK;
               end
               default: begin
                  s_axi_bresp <= `FSR_RESP_ERR;
               end
            endcase
         end
      end
   end

   // AXI read decode
   always @* begin
      axi_rd_ok = 1'b1;
      axi_rd_val = 32'h00000000;
      case (s_axi_araddr)
         `FSR_REG_CTRL: axi_rd_val = {31'h0, ctrl_fail_reg};
         `FSR_REG_PROT: axi_rd_val = {20'h0, prot_reg};
         `FSR_REG_STAT: axi_rd_val = {26'h0, busy, err_reg, state_reg};
         `FSR_REG_ID: axi_rd_val = {24'h0, MAIN_ID};
         default: axi_rd_ok = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // AXI read response
   always @(posedge mclk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FSR_RESP_OK;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= axi_rd_val;
            s_axi_rresp <= axi_rd_ok ? `FSR_RESP_OK : `FSR_RESP_ERR;
         end
      end
   end

endmodule // fsr_core

// [verification/fsir_chk.sv]
module fsir_chk (
   // Clock and reset
   input wire mclk,
   input wire srst,
   // Flash bus
   input wire mcu_rd,
   input wire [7:0] main_array_sector_select,
   input wire [3:0] secondary_array_sector_select,
   input wire [7:0] mcu_rdata,
   input wire mcu_rvalid,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Read strobe with any select high
   wire rd_tk = mcu_rd && (|main_array_sector_select ||
      |secondary_array_sector_select);
   sequence s_wr_tk;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   property p_rd_ans;
      rd_tk |=> mcu_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read strobe not answered");
   property p_rv_cause;
      mcu_rvalid |-> $past(rd_tk) && !$past(mcu_rvalid);
   endproperty
   a_rv_cause: assert property (p_rv_cause)
      else $error("read answer without a read");
   property p_rd_hold;
      !mcu_rvalid |-> $stable(mcu_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved between reads");
   property p_b_lat;
      s_wr_tk |-> !s_axi_bvalid ##2 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat)
      else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   property p_ar_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_ar_lat: assert property (p_ar_lat)
      else $error("read response late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read response dropped");
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0c |=>
         s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not refused");
   property p_aw_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_busy: assert property (p_aw_busy)
      else $error("write taken while answering");
   // Main scenarios reached
   c_rd: cover property (rd_tk);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // fsir_chk

bind fsr_core fsir_chk fsir_chk_u (.mclk, .srst, .mcu_rd,
   .main_array_sector_select, .secondary_array_sector_select,
   .mcu_rdata, .mcu_rvalid, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// [verification/fsir_mcu.sv]
`include "fsr_map.vh"

module fsir_mcu (
   // Clock and answer
   input wire mclk,
   input wire [7:0] mcu_rdata,
   input wire mcu_rvalid,
   // Bus cycle drive
   output logic [15:0] mcu_addr,
   output logic [7:0] mcu_wdata,
   output logic mcu_wr,
   output logic mcu_rd,
   output logic [7:0] main_array_sector_select,
   output logic [3:0] secondary_array_sector_select
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam [15:0] AD1 = {4'h0, `FSR_ADDR1};
   localparam [15:0] AD2 = {4'h0, `FSR_ADDR2};
   // Selects and strobes false at power-up
   initial begin
      mcu_addr = 16'h0;
      mcu_wdata = 8'h0;
      mcu_wr = 1'b0;
      mcu_rd = 1'b0;
      main_array_sector_select = 8'h0;
      secondary_array_sector_select = 4'h0;
   end
   // Choose the sector for following cycles
   task sel(input [7:0] m, input [3:0] s);
      main_array_sector_select <= m;
      secondary_array_sector_select <= s;
   endtask
   // One write cycle, released lines inverted
   task fw(input [15:0] a, input [7:0] d);
      mcu_addr <= a;
      mcu_wdata <= d;
      mcu_wr <= 1'b1;
      @(posedge mclk);
      mcu_wr <= 1'b0;
      mcu_addr <= ~a;
      mcu_wdata <= ~d;
      @(posedge mclk);
   endtask
   // One read cycle, waits for the answer
   task fr(input [15:0] a, output logic [7:0] d);
      mcu_addr <= a;
      mcu_rd <= 1'b1;
      @(posedge mclk);
      mcu_rd <= 1'b0;
      mcu_addr <= ~a;
      do begin
         @(posedge mclk);
      end while (!mcu_rvalid);
      d = mcu_rdata;
   endtask
   task cmd(input [7:0] c);
      fw(AD1, `FSR_UNLOCK1);
      fw(AD2, `FSR_UNLOCK2);
      fw(AD1, c);
   endtask
   task pgm(input [15:0] a, input [7:0] d);
      cmd(`FSR_CMD_PGM);
      fw(a, d);
   endtask
   // erase command: six writes, last data c picks sector or bulk erase
   task ers(input [7:0] c);
      cmd(`FSR_CMD_ERASE);
      fw(AD1, `FSR_UNLOCK1);
      fw(AD2, `FSR_UNLOCK2);
      fw(AD1, c);
   endtask
   task done(input [15:0] a, output logic [7:0] d);
      logic [7:0] p;
      begin
         fr(a, d);
         do begin
            p = d;
            fr(a, d);
         end while (d !== p);
      end
   endtask
endmodule // fsir_mcu

// [verification/flash_status_id_readout_bench.sv]
`include "fsr_map.vh"

module flash_status_id_readout_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam [7:0] ID_VAL = 8'h3c; // Arbitrary identifier value
   localparam [15:0] A = 16'h0003;
   logic mclk, srst;
   wire [15:0] mcu_addr;
   wire [7:0] mcu_wdata, mcu_rdata;
   wire mcu_wr, mcu_rd, mcu_rvalid;
   wire [7:0] main_array_sector_select;
   wire [3:0] secondary_array_sector_select;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [7:0] d, e;
   logic [31:0] rd32;
   logic [1:0] rs;
   int error_cnt = 0;
   int checked = 0;

   fsr_core #(.MAIN_ID(ID_VAL)) dut_u (.mclk, .srst, .mcu_addr,
      .mcu_wdata, .mcu_wr, .mcu_rd, .main_array_sector_select,
      .secondary_array_sector_select, .mcu_rdata, .mcu_rvalid,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   fsir_mcu mcu_u (.mclk, .mcu_rdata, .mcu_rvalid, .mcu_addr,
      .mcu_wdata, .mcu_wr, .mcu_rd, .main_array_sector_select,
      .secondary_array_sector_select);

   // Free-running clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Compare and count
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task test_done;
      $display("Checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Register write, address and data offered together
   task axw(input [7:0] a, input [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask
   // Register read
   task axr(input [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd32 = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask
   // Hang guard
   initial begin
      repeat (30000) @(posedge mclk);
      error_cnt++;
      test_done;
   end
   // Main sequence
   initial begin
      srst = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      axr(`FSR_REG_PROT);
      chk("prot_rst", rd32, 32'h0);
      axr(`FSR_REG_ID);
      chk("id_reg", rd32, {24'h0, ID_VAL});
      axw(`FSR_REG_ID, 32'h0);
      chk("ro_resp", rs, `FSR_RESP_OK);
      axr(8'h10);
      chk("unmap", rs, `FSR_RESP_ERR);
      axw(`FSR_REG_PROT, 32'h102);
      mcu_u.sel(8'h01, 4'h0);
      mcu_u.cmd(`FSR_CMD_ID);
      mcu_u.fr(16'h0001, d);
      chk("main_id", d, ID_VAL);
      mcu_u.sel(8'h02, 4'h0);
      mcu_u.fr(16'h0002, d);
      chk("prot_s1", d, 8'h01);
      mcu_u.sel(8'h00, 4'h1);
      mcu_u.fr(16'h0002, d);
      chk("prot_s8", d, 8'h01);
      mcu_u.sel(8'h04, 4'h0);
      mcu_u.fr(16'h0002, d);
      chk("prot_s2", d, 8'h00);
      mcu_u.sel(8'h01, 4'h0);
      mcu_u.fw(16'h0000, `FSR_CMD_RESET);
      // Sector erase with its window
      mcu_u.ers(`FSR_CMD_SECT);
      mcu_u.fr(A, d);
      chk("win_open", d[3], 1'b0);
      chk("poll_ers", d[7], 1'b0);
      chk("err_ok", d[5], 1'b0);
      repeat (2300) @(posedge mclk);
      mcu_u.fr(A, d);
      chk("win_held", d[3], 1'b0);
      repeat (200) @(posedge mclk);
      mcu_u.fr(A, d);
      chk("win_done", d[3], 1'b1);
      mcu_u.fr(16'h0009, e);
      chk("toggle", e[6] ^ d[6], 1'b1);
      chk("poll_any", e[7], 1'b0);
      mcu_u.done(A, d);
      chk("erased", d, 8'hff);
      // Program and read back
      mcu_u.pgm(A, 8'h5c);
      mcu_u.fr(A, d);
      chk("poll_pgm", d[7], 1'b1);
      mcu_u.done(A, d);
      chk("pgm_val", d, 8'h5c);
      // Protected sector refuses program and erase
      axw(`FSR_REG_PROT, 32'h103);
      mcu_u.pgm(A, 8'h00);
      mcu_u.fr(A, d);
      chk("prot_pgm", d, 8'h5c);
      mcu_u.ers(`FSR_CMD_SECT);
      repeat (2500) @(posedge mclk);
      mcu_u.fr(A, d);
      mcu_u.fr(A, e);
      chk("prot_ers", {d[7:6], e[7:6]}, 4'h0);
      repeat (2100) @(posedge mclk);
      mcu_u.fr(A, d);
      chk("no_erase", d, 8'h5c);
      // Whole secondary array with sector 8 protected, erase checked in sector 9 only
      mcu_u.sel(8'h00, 4'h2);
      mcu_u.ers(`FSR_CMD_BULK);
      mcu_u.done(16'h0007, d);
      chk("bulk", d, 8'hff);
      // Raising a cleared bit fails until reset
      axw(`FSR_REG_PROT, 32'h102);
      mcu_u.sel(8'h01, 4'h0);
      mcu_u.pgm(A, 8'hff);
      repeat (40) @(posedge mclk);
      mcu_u.fr(A, d);
      chk("err_set", d[5], 1'b1);
      mcu_u.fr(A, d);
      chk("err_stays", d[5], 1'b1);
      mcu_u.fw(16'h0000, `FSR_CMD_RESET);
      mcu_u.fr(A, d);
      chk("err_clr", d, 8'h5c);
      // Forced erase failure in another sector
      axw(`FSR_REG_CTRL, 32'h1);
      mcu_u.sel(8'h04, 4'h0);
      mcu_u.ers(`FSR_CMD_SECT);
      mcu_u.sel(8'h08, 4'h0);
      mcu_u.fw(A, `FSR_CMD_SECT);
      mcu_u.fr(A, d);
      chk("win_next", d[3], 1'b1);
      repeat (2800) @(posedge mclk);
      mcu_u.fr(16'h000e, d);
      chk("ers_fail", d[5], 1'b1);
      mcu_u.fw(16'h0000, `FSR_CMD_RESET);
      // Forced timeout on a program
      mcu_u.pgm(A, 8'h00);
      repeat (40) @(posedge mclk);
      mcu_u.fr(A, d);
      chk("pgm_tmo", d[5], 1'b1);
      mcu_u.fw(16'h0000, `FSR_CMD_RESET);
      axr(`FSR_REG_STAT);
      chk("stat_idle", rd32[5:0], 6'h00);
      test_done;
   end
endmodule // flash_status_id_readout_bench
